// ==== logic/pdcc_regs.svh ====
// Purpose: register offsets, field positions, reset values and wait counts
// Assumes: APB byte addresses, 8-bit registers in the low byte of a word
// Notes: definitions only
`ifndef PDCC_REGS_SVH
`define PDCC_REGS_SVH

`define PDC_ADDR_W 12
`define PDC_OFF_CTL1 12'h000
`define PDC_OFF_CTL2 12'h004

`define PDC_CTL1_RESET 8'h00
`define PDC_CTL2_RESET 8'h00

`define PDC_BIT_STANDBY 7
`define PDC_WTIME_MSB 6
`define PDC_WTIME_LSB 4
`define PDC_BIT_KIND 7
`define PDC_BIT_DIRECT 5
`define PDC_CLKSEL_MSB 4
`define PDC_CLKSEL_LSB 2

`define PDC_CNT_W 18
`define PDC_WAIT_000 18'h02000
`define PDC_WAIT_001 18'h04000
`define PDC_WAIT_010 18'h08000
`define PDC_WAIT_011 18'h10000
`define PDC_WAIT_100 18'h20000
`define PDC_WAIT_101 18'h00400
`define PDC_WAIT_110 18'h00080
`define PDC_WAIT_111 18'h00010

`define PDC_DIV_W 6
`define PDC_DIV1_LIM 6'h00
`define PDC_DIV8_LIM 6'h07
`define PDC_DIV16_LIM 6'h0f
`define PDC_DIV32_LIM 6'h1f
`define PDC_DIV64_LIM 6'h3f

`endif

// ==== logic/pdcc_pkg.sv ====
// Purpose: types shared by the power-down clock control files
// Assumes: field widths fixed
// Notes: enums use explicit binary codes
package pdcc_pkg;

	typedef enum logic [2:0] {
		MODE_ACTIVE = 3'b000,
		MODE_SLEEP = 3'b001,
		MODE_SUBSLEEP = 3'b010,
		MODE_STANDBY = 3'b011,
		MODE_WAIT = 3'b100,
		MODE_EXT_WAIT = 3'b101
	} mode_t;

	typedef enum logic [1:0] {
		SRC_MAIN = 2'b00,
		SRC_ONCHIP = 2'b01,
		SRC_EXT = 2'b10
	} clk_src_t;

	typedef struct packed {
		logic software_standby_bit;
		logic [2:0] wait_time;
	} ctl1_t;

	typedef struct packed {
		logic sleep_kind_select;
		logic direct_transition_flag;
		logic [2:0] active_clock_sel;
	} ctl2_t;

endpackage

// ==== logic/wait_state_counter.sv ====
// Purpose: counts oscillation-stabilization wait states on the on-chip tick
// Assumes: onchip_tick is a one-cycle pulse per on-chip oscillator state
// Notes: exactly the selected count of ticks elapses before done
`timescale 1ns/1ps
`include "pdcc_regs.svh"
module wait_state_counter #(
	parameter int unsigned WAIT_8192 = `PDC_WAIT_000,
	parameter int unsigned WAIT_16384 = `PDC_WAIT_001,
	parameter int unsigned WAIT_32768 = `PDC_WAIT_010,
	parameter int unsigned WAIT_65536 = `PDC_WAIT_011,
	parameter int unsigned WAIT_131072 = `PDC_WAIT_100
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [2:0] code,
	input wire logic onchip_tick,
	output logic busy,
	output logic done
);
	import pdcc_pkg::*;

	function automatic logic [`PDC_CNT_W-1:0] wait_len(input logic [2:0] c);
		case (c)
			3'b000: wait_len = `PDC_CNT_W'(WAIT_8192);
			3'b001: wait_len = `PDC_CNT_W'(WAIT_16384);
			3'b010: wait_len = `PDC_CNT_W'(WAIT_32768);
			3'b011: wait_len = `PDC_CNT_W'(WAIT_65536);
			3'b100: wait_len = `PDC_CNT_W'(WAIT_131072);
			3'b101: wait_len = `PDC_WAIT_101;
			3'b110: wait_len = `PDC_WAIT_110;
			default: wait_len = `PDC_WAIT_111;
		endcase
	endfunction

	logic [`PDC_CNT_W-1:0] remain;
	logic [`PDC_CNT_W-1:0] target;
	logic [`PDC_CNT_W-1:0] seen;
	wire last_tick = busy && onchip_tick && (remain == `PDC_CNT_W'(1));

	// counting one nominal length sits inside the one-to-two-times window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remain <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= last_tick;
			if (start) begin
				remain <= wait_len(code); // see R3
				busy <= 1'b1;
			end else if (busy && onchip_tick) begin
				remain <= remain - `PDC_CNT_W'(1); // see R5
				busy <= !last_tick;
			end
		end
	end

	// helper state only the checks read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			target <= '0;
			seen <= '0;
		end else if (start) begin
			target <= wait_len(code);
			seen <= '0;
		end else if (busy && onchip_tick) begin
			seen <= seen + `PDC_CNT_W'(1);
		end
	end

	a_wait_exact_count: assert property (@(posedge pclk) disable iff (!presetn) // see R5
		done |-> (seen == target))
		else $error("wait ended after the wrong number of states");
	a_wait_code_len: assert property (@(posedge pclk) disable iff (!presetn) // see R3
		start && code == 3'b111 |=> busy && remain == `PDC_WAIT_111)
		else $error("shortest wait code did not load sixteen states");

endmodule

// ==== logic/power_down_clock_control.sv ====
// Purpose: power-down mode and system clock control behind two APB registers
// Assumes: sleep_exec, wake_irq, ext_switch_req, onchip_tick are one-cycle pulses
// Notes: sys_tick marks each system clock period as a pclk-wide pulse
//
// Behaviour
// R1: leaving standby, hold off the main clock for the wait from oscillator restart.
// R2: during the wait the system clock runs from the on-chip oscillator.
// R3: wait code selects 8192,16384,32768,65536,131072,1024,128 or 16 states.
// R4: the same wait code times the switch to the external clock.
// R5: counted wait lies between the nominal count and twice it.
// R6: wait states are counted on the on-chip clock even with external clock.
// R7: software picks a wait of at least 6.5 ms for resonators.
// R8: external clock needs 100 us wait, or the shortest code on masked ROM.
// R9: reserved bits of both control registers read as zero.
// R10: second register bit 7 selects sleep kind, resets to zero.
// R11: second register bit 5 is the direct-transition flag, resets to zero.
// R12: active clock field bits 4..2 takes effect only after the sleep instruction.
// R13: codes 0xx give the undivided clock, code 101 divides by 16.
// R14: code 100 divides by 8, 110 by 32, 111 by 64.
// R15: writes to reserved bits are dropped and leave no state.
// R16: standby bit 7 of the first register picks sleep (0) or standby (1).
// R17: sleep instruction mode table; an interrupt returns to active mode.
// R18: active clock is the oscillator undivided or divided by 8, 16, 32, 64.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "pdcc_regs.svh"
module power_down_clock_control #(
	parameter int unsigned WAIT_8192 = `PDC_WAIT_000,
	parameter int unsigned WAIT_16384 = `PDC_WAIT_001,
	parameter int unsigned WAIT_32768 = `PDC_WAIT_010,
	parameter int unsigned WAIT_65536 = `PDC_WAIT_011,
	parameter int unsigned WAIT_131072 = `PDC_WAIT_100
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PDC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_exec,
	input wire logic wake_irq,
	input wire logic ext_switch_req,
	input wire logic onchip_tick,
	output pdcc_pkg::mode_t mode,
	output pdcc_pkg::clk_src_t clk_src,
	output logic main_osc_enable,
	output logic [2:0] applied_clock_sel,
	output logic sys_tick,
	output logic cpu_halt,
	output logic wait_busy
);
	import pdcc_pkg::*;

	function automatic logic [`PDC_DIV_W-1:0] div_limit(input logic [2:0] sel);
		case (sel)
			3'b100: div_limit = `PDC_DIV8_LIM;
			3'b101: div_limit = `PDC_DIV16_LIM;
			3'b110: div_limit = `PDC_DIV32_LIM;
			3'b111: div_limit = `PDC_DIV64_LIM;
			default: div_limit = `PDC_DIV1_LIM;
		endcase
	endfunction

	ctl1_t system_control_one;
	ctl2_t system_control_two;
	mode_t next_mode;
	clk_src_t next_clk_src;
	logic use_ext;
	logic [`PDC_DIV_W-1:0] div_cnt;
	logic wait_done;

	// apb decode
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hit_one = (paddr == `PDC_OFF_CTL1);
	wire hit_two = (paddr == `PDC_OFF_CTL2);
	wire mapped = hit_one || hit_two;
	wire wr_one = access && pwrite && hit_one;
	wire wr_two = access && pwrite && hit_two;

	// only writable positions are captured; the rest never reach a flop
	wire ctl1_t wdata_one = '{
		software_standby_bit: pwdata[`PDC_BIT_STANDBY],
		wait_time: pwdata[`PDC_WTIME_MSB:`PDC_WTIME_LSB]
	}; // see R15
	wire ctl2_t wdata_two = '{
		sleep_kind_select: pwdata[`PDC_BIT_KIND],
		direct_transition_flag: pwdata[`PDC_BIT_DIRECT],
		active_clock_sel: pwdata[`PDC_CLKSEL_MSB:`PDC_CLKSEL_LSB]
	}; // see R15

	wire [7:0] rd_one = {system_control_one, 4'h0}; // see R9
	wire [7:0] rd_two = {system_control_two.sleep_kind_select, 1'b0,
		system_control_two.direct_transition_flag,
		system_control_two.active_clock_sel, 2'b00}; // see R9
	wire [7:0] rd_sel = hit_one ? rd_one : (hit_two ? rd_two : 8'h00);

	// zero-wait slave; read data is captured in setup so it is a flop at access
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= {24'h00_0000, rd_sel};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_control_one <= ctl1_t'(`PDC_CTL1_RESET >> 4);
			system_control_two <= ctl2_t'(5'h00); // see R10 R11
		end else begin
			if (wr_one)
				system_control_one <= wdata_one; // see R16
			if (wr_two)
				system_control_two <= wdata_two;
		end
	end

	// mode decode on the sleep instruction
	wire standby_sel = system_control_one.software_standby_bit;
	wire kind_sel = system_control_two.sleep_kind_select;
	wire direct_sel = system_control_two.direct_transition_flag;
	wire in_active = (mode == MODE_ACTIVE);
	wire sleep_now = in_active && sleep_exec;
	wire ext_start = in_active && !sleep_exec && ext_switch_req && (clk_src != SRC_EXT);
	wire standby_wake = (mode == MODE_STANDBY) && wake_irq;
	wire wait_start = standby_wake || ext_start;

	// direct transition with the kind select set is left undefined; it is kept in active mode
	// staying active there is the safest guess: software keeps control and can retry
	always_comb begin
		next_mode = mode;
		next_clk_src = clk_src;
		case (mode)
			MODE_ACTIVE: begin
				if (sleep_exec) begin
					if (direct_sel)
						next_mode = MODE_ACTIVE; // see R17
					else if (standby_sel)
						next_mode = MODE_STANDBY; // see R16
					else if (kind_sel)
						next_mode = MODE_SUBSLEEP; // see R10
					else
						next_mode = MODE_SLEEP; // see R17
				end else if (ext_start) begin
					next_mode = MODE_EXT_WAIT;
					next_clk_src = SRC_ONCHIP; // see R4
				end
			end
			MODE_SLEEP, MODE_SUBSLEEP: begin
				if (wake_irq)
					next_mode = MODE_ACTIVE; // see R17
			end
			MODE_STANDBY: begin
				if (wake_irq) begin
					next_mode = MODE_WAIT; // see R1
					next_clk_src = SRC_ONCHIP; // see R2
				end
			end
			MODE_WAIT: begin
				if (wait_done) begin
					next_mode = MODE_ACTIVE;
					next_clk_src = use_ext ? SRC_EXT : SRC_MAIN; // see R1
				end
			end
			MODE_EXT_WAIT: begin
				if (wait_done) begin
					next_mode = MODE_ACTIVE;
					next_clk_src = SRC_EXT; // see R4
				end
			end
			default: begin
				next_mode = MODE_ACTIVE;
				next_clk_src = SRC_MAIN;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= MODE_ACTIVE;
			clk_src <= SRC_MAIN;
		end else begin
			mode <= next_mode;
			clk_src <= next_clk_src;
		end
	end

	// the oscillator is stopped in standby and restarts on the wake itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_osc_enable <= 1'b1;
			use_ext <= 1'b0;
		end else begin
			if (sleep_now && !direct_sel && standby_sel)
				main_osc_enable <= 1'b0;
			else if (standby_wake)
				main_osc_enable <= 1'b1; // see R1
			if (mode == MODE_EXT_WAIT && wait_done)
				use_ext <= 1'b1;
		end
	end

	// a new divider code only lands when the sleep instruction runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			applied_clock_sel <= 3'b000;
		else if (sleep_now)
			applied_clock_sel <= system_control_two.active_clock_sel; // see R12
	end

	wire [`PDC_DIV_W-1:0] lim = div_limit(applied_clock_sel); // see R13 R14
	wire clk_runs = (mode == MODE_ACTIVE) || (mode == MODE_SLEEP);
	wire on_onchip = (mode == MODE_WAIT) || (mode == MODE_EXT_WAIT);
	wire div_wrap = (div_cnt >= lim);

	// restarting the divider on a code change trades one long period for no glitch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= '0;
			sys_tick <= 1'b0;
		end else begin
			if (sleep_now || !clk_runs || div_wrap)
				div_cnt <= '0;
			else
				div_cnt <= div_cnt + `PDC_DIV_W'(1);
			if (on_onchip)
				sys_tick <= onchip_tick; // see R2
			else
				sys_tick <= clk_runs && !sleep_now && div_wrap; // see R18
		end
	end

	assign cpu_halt = (mode != MODE_ACTIVE);

	// counts on the on-chip tick whatever the selected source
	wait_state_counter #(
		.WAIT_8192(WAIT_8192),
		.WAIT_16384(WAIT_16384),
		.WAIT_32768(WAIT_32768),
		.WAIT_65536(WAIT_65536),
		.WAIT_131072(WAIT_131072)
	) u_wait (
		.pclk(pclk),
		.presetn(presetn),
		.start(wait_start),
		.code(system_control_one.wait_time), // see R3 R4
		.onchip_tick(onchip_tick), // see R6
		.busy(wait_busy),
		.done(wait_done)
	);

	sequence s_standby_wake;
		mode == MODE_STANDBY && wake_irq;
	endsequence

	sequence s_enter_wait;
		mode == MODE_WAIT && main_osc_enable && wait_busy && clk_src == SRC_ONCHIP;
	endsequence

	sequence s_ext_done;
		mode == MODE_EXT_WAIT && wait_done;
	endsequence

	sequence s_wait_over;
		mode == MODE_WAIT && wait_done;
	endsequence

	// a second switch request on the external clock must not restart the wait
	sequence s_ext_refused;
		in_active && ext_switch_req && !sleep_exec && clk_src == SRC_EXT;
	endsequence

	a_wake_restarts_wait: assert property (@(posedge pclk) disable iff (!presetn) // see R1
		s_standby_wake |=> s_enter_wait)
		else $error("standby wake did not restart oscillator and wait");
	a_standby_osc_off: assert property (@(posedge pclk) disable iff (!presetn) // see R1
		mode == MODE_STANDBY |-> !main_osc_enable && !sys_tick)
		else $error("clock running in standby");
	a_wait_on_onchip: assert property (@(posedge pclk) disable iff (!presetn) // see R2
		(mode == MODE_WAIT || mode == MODE_EXT_WAIT) |-> clk_src == SRC_ONCHIP
			##1 (sys_tick == $past(onchip_tick) || mode == MODE_ACTIVE))
		else $error("wait not clocked from on-chip oscillator");
	a_ext_switch_end: assert property (@(posedge pclk) disable iff (!presetn) // see R4
		s_ext_done |=> mode == MODE_ACTIVE && clk_src == SRC_EXT)
		else $error("external switch did not finish on external clock");
	a_ctl_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // see R9
		access && !pwrite && mapped |-> prdata[31:8] == 24'h00_0000
			&& prdata[1:0] == 2'b00 && (!hit_one || prdata[3:0] == 4'h0)
			&& (!hit_two || !prdata[6]))
		else $error("reserved bits read nonzero");
	a_sleep_table: assert property (@(posedge pclk) disable iff (!presetn) // see R17
		sleep_now && !direct_sel |=> mode == ($past(standby_sel) ? MODE_STANDBY :
			($past(kind_sel) ? MODE_SUBSLEEP : MODE_SLEEP)))
		else $error("sleep instruction entered wrong mode");
	a_direct_stays: assert property (@(posedge pclk) disable iff (!presetn) // see R11
		sleep_now && direct_sel |=> mode == MODE_ACTIVE && cpu_halt == 1'b0)
		else $error("direct transition left active mode");
	a_div_held: assert property (@(posedge pclk) disable iff (!presetn) // see R12
		!sleep_now |=> $stable(applied_clock_sel))
		else $error("clock select changed without sleep instruction");
	a_div_applied: assert property (@(posedge pclk) disable iff (!presetn) // see R12
		sleep_now |=> applied_clock_sel == $past(system_control_two.active_clock_sel))
		else $error("clock select not applied on sleep instruction");
	a_div16_gap: assert property (@(posedge pclk) disable iff (!presetn) // see R13
		sys_tick && mode == MODE_ACTIVE && applied_clock_sel == 3'b101 && !sleep_exec
			&& !ext_switch_req |=> !sys_tick [*8])
		else $error("divide-by-16 clock ticked too soon");
	a_undiv_runs: assert property (@(posedge pclk) disable iff (!presetn) // see R13
		mode == MODE_ACTIVE && !applied_clock_sel[2] && !sleep_exec && !ext_switch_req
			&& $past(mode == MODE_ACTIVE && !sleep_exec) |=> sys_tick)
		else $error("undivided clock skipped a cycle");
	a_reserved_write: assert property (@(posedge pclk) disable iff (!presetn) // see R15
		wr_two |=> rd_two == ($past(pwdata[7:0]) & 8'hbc))
		else $error("reserved write left state");
	a_reserved_write_one: assert property (@(posedge pclk) disable iff (!presetn) // see R15
		wr_one |=> rd_one == ($past(pwdata[7:0]) & 8'hf0))
		else $error("reserved write to first register left state");

	// wake, refusal, active-oscillator and subsleep paths; a short wait is what a marginal oscillator exposes first
	a_wait_returns: assert property (@(posedge pclk) disable iff (!presetn) // see R1 R2
		s_wait_over |=> mode == MODE_ACTIVE && clk_src != SRC_ONCHIP && !wait_busy)
		else $error("wait end did not restore a steady clock");
	a_osc_runs_active: assert property (@(posedge pclk) disable iff (!presetn) // see R1
		mode == MODE_ACTIVE |-> main_osc_enable)
		else $error("oscillator stopped in active mode");
	a_wake_returns: assert property (@(posedge pclk) disable iff (!presetn) // see R17
		(mode == MODE_SLEEP || mode == MODE_SUBSLEEP) && wake_irq |=> mode == MODE_ACTIVE
			&& !cpu_halt)
		else $error("interrupt did not return to active mode");
	a_subsleep_quiet: assert property (@(posedge pclk) disable iff (!presetn) // see R17
		mode == MODE_SUBSLEEP |-> !sys_tick && main_osc_enable)
		else $error("system clock ticked in subsleep");
	a_ext_refused: assert property (@(posedge pclk) disable iff (!presetn) // see R4
		s_ext_refused |=> mode == MODE_ACTIVE && clk_src == SRC_EXT)
		else $error("switch request on external clock restarted the wait");

endmodule

// ==== verif/power_down_clock_control_tb.sv ====
// Purpose: self-checking bench for the power-down clock control block
// Assumes: APB with zero wait states; small stand-ins for the five long wait counts
// Notes: on-chip tick runs free, one pulse every third pclk cycle
`timescale 1ns/1ps
`include "pdcc_regs.svh"
module power_down_clock_control_tb;
	import pdcc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [`PDC_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic sleep_exec, wake_irq, ext_switch_req;
	logic onchip_tick = 1'b0;
	logic main_osc_enable, sys_tick, cpu_halt, wait_busy, err;
	logic [2:0] applied_clock_sel;
	logic [1:0] tdiv = 2'd0;
	mode_t mode;
	clk_src_t clk_src;
	int error_cnt = 0;
	int cmp_count = 0;
	int n, c;

	// long counts shrunk so every code can be walked in one run
	power_down_clock_control #(.WAIT_8192(20), .WAIT_16384(24), .WAIT_32768(28),
		.WAIT_65536(32), .WAIT_131072(36)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_exec(sleep_exec), .wake_irq(wake_irq), .ext_switch_req(ext_switch_req),
		.onchip_tick(onchip_tick), .mode(mode), .clk_src(clk_src),
		.main_osc_enable(main_osc_enable), .applied_clock_sel(applied_clock_sel),
		.sys_tick(sys_tick), .cpu_halt(cpu_halt), .wait_busy(wait_busy));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		tdiv <= (tdiv == 2'd2) ? 2'd0 : tdiv + 2'd1;
		onchip_tick <= (tdiv == 2'd2);
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task apb(input logic wr, input logic [`PDC_ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// only the watchdog ends a slave that never answers
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// k: 0 sleep instruction, 1 interrupt, 2 external clock request
	task ev(input int k);
		@(posedge pclk);
		sleep_exec <= (k == 0);
		wake_irq <= (k == 1);
		ext_switch_req <= (k == 2);
		@(posedge pclk);
		{sleep_exec, wake_irq, ext_switch_req} <= 3'b000;
		#1;
	endtask

	task count_wait(output int cnt);
		int k;
		cnt = 0;
		for (k = 0; k < 5000 && mode !== MODE_ACTIVE; k++) begin
			if (onchip_tick === 1'b1)
				cnt++;
			@(posedge pclk);
			#1;
		end
	endtask

	task tick_period(output int p);
		int k;
		p = 0;
		for (k = 0; k < 200 && sys_tick !== 1'b1; k++) begin
			@(posedge pclk);
			#1;
		end
		for (k = 0; k < 200; k++) begin
			@(posedge pclk);
			#1;
			p++;
			if (sys_tick === 1'b1)
				break;
		end
	endtask

	function automatic int wait_n(input int code);
		int t[8] = '{20, 24, 28, 32, 36, 1024, 128, 16};
		return t[code];
	endfunction

	function automatic int div_n(input int code);
		int t[8] = '{1, 1, 1, 1, 8, 16, 32, 64};
		return t[code];
	endfunction

	task summarize;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// generous bound: the whole sequence needs well under 10000 cycles
	initial begin
		repeat (60000) @(posedge pclk);
		error_cnt++;
		$display("BAD %0t watchdog expired", $time);
		summarize;
	end

	initial begin
		{presetn, psel, penable, pwrite, sleep_exec, wake_irq, ext_switch_req} <= 7'b0;
		paddr <= '0;
		pwdata <= '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `PDC_OFF_CTL1, 32'h0);
		chk(rd, 32'h0, "ctl1 reset");
		apb(1'b0, `PDC_OFF_CTL2, 32'h0);
		chk(rd, 32'h0, "ctl2 reset");
		apb(1'b1, `PDC_OFF_CTL1, 32'hffff_ffff);
		apb(1'b0, `PDC_OFF_CTL1, 32'h0);
		chk(rd, 32'hf0, "ctl1 reserved");
		apb(1'b1, `PDC_OFF_CTL2, 32'hffff_ffff);
		apb(1'b0, `PDC_OFF_CTL2, 32'h0);
		chk(rd, 32'hbc, "ctl2 reserved");
		apb(1'b1, 12'h008, 32'h5a);
		chk({31'h0, err}, 32'h1, "unmapped err");
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h0, "unmapped data");
		apb(1'b1, `PDC_OFF_CTL1, 32'h0);
		ev(1);
		chk(mode, MODE_ACTIVE, "irq in active");
		// direct transition: new divider only after the sleep instruction
		for (c = 0; c < 8; c++) begin
			apb(1'b1, `PDC_OFF_CTL2, 32'h20 | (c << 2));
			chk(applied_clock_sel, (c == 0) ? 0 : c - 1, "divider early");
			ev(0);
			chk(mode, MODE_ACTIVE, "direct stays active");
			chk(applied_clock_sel, c, "divider applied");
			tick_period(n);
			chk(n, div_n(c), "tick period");
		end
		apb(1'b1, `PDC_OFF_CTL2, 32'h00);
		ev(0);
		chk(mode, MODE_SLEEP, "sleep entry");
		chk(cpu_halt, 1'b1, "sleep halts cpu");
		ev(1);
		chk(mode, MODE_ACTIVE, "sleep wake");
		apb(1'b1, `PDC_OFF_CTL2, 32'h80);
		ev(0);
		chk(mode, MODE_SUBSLEEP, "subsleep entry");
		ev(1);
		chk(mode, MODE_ACTIVE, "subsleep wake");
		apb(1'b1, `PDC_OFF_CTL2, 32'h00);
		for (c = 0; c < 8; c++) begin
			// every code is walked here; a resonator board keeps to the long ones
			apb(1'b1, `PDC_OFF_CTL1, 32'h80 | (c << 4));
			ev(0);
			chk(mode, MODE_STANDBY, "standby entry");
			chk(main_osc_enable, 1'b0, "osc stopped");
			ev(1);
			chk(mode, MODE_WAIT, "wait entry");
			chk(clk_src, SRC_ONCHIP, "wait on onchip");
			chk({main_osc_enable, wait_busy}, 2'b11, "osc restart");
			count_wait(n);
			chk(32'(n >= wait_n(c) && n <= 2 * wait_n(c)), 32'd1, "wait window");
			chk(n, wait_n(c), "wait length");
			chk(mode, MODE_ACTIVE, "back active");
			chk(clk_src, SRC_MAIN, "main clock back");
		end
		// shortest code, as advised for an external clock
		apb(1'b1, `PDC_OFF_CTL1, 32'h70);
		ev(2);
		chk(mode, MODE_EXT_WAIT, "ext wait");
		chk(clk_src, SRC_ONCHIP, "ext wait onchip");
		count_wait(n);
		chk(n, 32'd16, "ext wait length");
		chk(clk_src, SRC_EXT, "external in use");
		ev(2);
		chk(mode, MODE_ACTIVE, "ext again refused");
		apb(1'b1, `PDC_OFF_CTL1, 32'hf0);
		ev(0);
		ev(1);
		chk(clk_src, SRC_ONCHIP, "ext wake onchip");
		count_wait(n);
		chk(n, 32'd16, "ext wake length");
		chk(clk_src, SRC_EXT, "external after wake");
		summarize;
	end
endmodule
